/* hw/cis_defs.vh */
// Constants for the interrupt sequencer: vectors, flag positions, timing.
// Assumes inclusion by bare name from the design files.
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH

// Flag register bit positions
`define CIS_CCR_H 4
`define CIS_CCR_I 3
`define CIS_CCR_N 2
`define CIS_CCR_Z 1
`define CIS_CCR_C 0
`define CIS_CCR_ONES 3'h7
`define CIS_PC_ONES 3'h7

// Stack window
`define CIS_SP_RESET 6'h3F
`define CIS_SP_HIGH 10'h003

// Vector addresses (high byte; low byte follows)
`define CIS_VEC_RESET 16'h1FFE
`define CIS_VEC_SWI 16'h1FFC
`define CIS_VEC_EXT 16'h1FFA
`define CIS_VEC_CTIM 16'h1FF8
`define CIS_VEC_PTIM 16'h1FF6
`define CIS_VEC_SER 16'h1FF4
`define CIS_VEC_ANA 16'h1FF2

// Source codes, in priority order
`define CIS_SRC_RESET 3'h0
`define CIS_SRC_SWI 3'h1
`define CIS_SRC_EXT 3'h2
`define CIS_SRC_CTIM 3'h3
`define CIS_SRC_PTIM 3'h4
`define CIS_SRC_SER 3'h5
`define CIS_SRC_ANA 3'h6

// Stacked byte counts
`define CIS_INT_BYTES 3'h5
`define CIS_CALL_BYTES 3'h2

// Flag-update operation codes
`define CIS_OP_NONE 3'h0
`define CIS_OP_ADD 3'h1
`define CIS_OP_ADC 3'h2
`define CIS_OP_SUB 3'h3
`define CIS_OP_SBC 3'h4
`define CIS_OP_LOGIC 3'h5
`define CIS_OP_SETC 3'h6
`define CIS_OP_CLRC 3'h7

// Multiply length in clock cycles
`define CIS_MUL_CYCLES 4'hB

`endif

/* hw/cis_multiplier.v */
// Add-and-shift 8x8 multiplier for the sequencer.
// Assumes operands are stable only in the start cycle.
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_multiplier
(
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Operands
    input wire i_start,
    input wire [7:0] i_a,
    input wire [7:0] i_x,
    // Result
    output wire o_busy,
    output wire o_done,
    output wire [15:0] o_product
);

reg [16:0] acc_ff;
reg [16:0] nxt_acc;
reg [7:0] mcand_ff;
reg [3:0] cnt_ff;
reg done_ff;
reg [8:0] part;

always @*
begin
    part = {1'b0, acc_ff[15:8]} + {1'b0, mcand_ff};
    nxt_acc = acc_ff;
    if (cnt_ff >= 4'h1 && cnt_ff <= 4'h8)
    begin
        if (acc_ff[0])
            nxt_acc = {1'b0, part, acc_ff[7:1]};
        else
            nxt_acc = acc_ff >> 1;
    end
end

always @(posedge i_clk)
begin
    if (!i_nrst)
    begin
        acc_ff <= 17'h00000;
        mcand_ff <= 8'h00;
        cnt_ff <= 4'h0;
        done_ff <= 1'b0;
    end
    else
    begin
        done_ff <= (cnt_ff == `CIS_MUL_CYCLES - 4'h1);
        if (i_start && cnt_ff == 4'h0)
        begin
            acc_ff <= {9'h000, i_x};
            mcand_ff <= i_a;
            cnt_ff <= 4'h1;
        end
        else if (cnt_ff != 4'h0)
        begin
            acc_ff <= nxt_acc;
            if (cnt_ff == `CIS_MUL_CYCLES - 4'h1)
                cnt_ff <= 4'h0;
            else
                cnt_ff <= cnt_ff + 4'h1;
        end
    end
end

assign o_busy = (cnt_ff != 4'h0) | done_ff;
assign o_done = done_ff;
assign o_product = acc_ff[15:0];

endmodule // cis_multiplier

/* hw/cis_core.v */
// Interrupt sequencer: instruction address, flags, stack and vectoring.
// Assumes the core holds off while o_busy is high and that stack/vector
// memory returns read data one cycle after o_mem_req.
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_core
(
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Instruction stream
    input wire i_fetch,
    input wire i_jump,
    input wire [15:0] i_jump_addr,
    input wire i_instr_done,
    input wire i_clear_mask_instruction,
    input wire i_set_mask_instr,
    input wire i_software_trap_instr,
    input wire i_return_from_handler_instr,
    input wire i_call_instr,
    input wire i_return_instr,
    input wire [7:0] i_acc,
    input wire [7:0] i_idx,
    // Flag updates and multiply
    input wire [2:0] i_alu_op,
    input wire [7:0] i_alu_a,
    input wire [7:0] i_alu_b,
    input wire i_multiply_instr,
    // Reset sources
    input wire [3:0] i_reset_sources,
    input wire i_watchdog_timeout,
    input wire i_watchdog_enable_option,
    // External requests
    input wire i_ext_pin_n,
    input wire [3:0] i_port_a_low_pins,
    input wire i_port_a_request_option,
    input wire i_ext_request_enable,
    input wire i_ext_clear,
    // Peripheral flags and enables
    input wire i_core_timer_overflow_flag,
    input wire i_core_timer_overflow_enable,
    input wire i_periodic_tick_flag,
    input wire i_periodic_tick_enable,
    input wire i_capture_flag,
    input wire i_capture_int_enable,
    input wire i_compare_flag,
    input wire i_compare_int_enable,
    input wire i_prog_timer_overflow_flag,
    input wire i_prog_timer_overflow_enable,
    input wire i_serial_done_flag,
    input wire i_serial_int_enable,
    input wire i_comparator_one_flag,
    input wire i_comparator_two_flag,
    input wire i_comparator_int_enable,
    // Stack and vector memory
    output wire o_mem_req,
    output wire o_mem_we,
    output wire [15:0] o_mem_addr,
    output wire [7:0] o_mem_wdata,
    input wire [7:0] i_mem_rdata,
    // Status
    output wire [15:0] o_pc,
    output wire [7:0] o_ccr,
    output wire [15:0] o_sp_addr,
    output wire o_busy,
    output wire [7:0] o_alu_result,
    output wire [15:0] o_mul_product,
    output wire o_mul_done,
    output wire o_restore_valid,
    output wire [7:0] o_restore_acc,
    output wire [7:0] o_restore_idx,
    output wire [4:0] o_vec_ack,
    output wire o_ext_pending,
    output wire o_reset_req
);

localparam S_RUN = 2'h0;
localparam S_PUSH = 2'h1;
localparam S_PULL = 2'h2;
localparam S_VEC = 2'h3;

localparam K_INT = 1'b0;
localparam K_SUB = 1'b1;

reg [1:0] state_ff;
reg kind_ff;
reg [2:0] cnt_ff;
reg ph_ff;
reg [2:0] src_ff;
reg [15:0] pc_ff;
reg [15:0] tgt_ff;
reg [5:0] sp_ff;
reg i_bit_ff;
reg h_ff;
reg n_ff;
reg z_ff;
reg c_ff;
reg [7:0] alu_res_ff;
reg [7:0] rest_acc_ff;
reg [7:0] rest_idx_ff;
reg rest_valid_ff;
reg [7:0] rest_ccr_ff;
reg [7:0] vec_hi_ff;
reg ext_meta_ff;
reg ext_sync_ff;
reg ext_prev_ff;
reg [3:0] pa_meta_ff;
reg [3:0] pa_sync_ff;
reg [3:0] pa_prev_ff;
reg ext_pend_ff;

wire mul_busy;
wire mul_done;
wire [15:0] mul_product;

cis_multiplier u_mul
(
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(i_multiply_instr),
    .i_a(i_alu_a),
    .i_x(i_alu_b),
    .o_busy(mul_busy),
    .o_done(mul_done),
    .o_product(mul_product)
);

// Request qualification
wire [3:0] pa_rise = pa_sync_ff & ~pa_prev_ff;
wire ext_set = (ext_prev_ff & ~ext_sync_ff) |
    (i_port_a_request_option & (|pa_rise));
wire ext_req = ext_pend_ff & i_ext_request_enable;
wire ctim_req = (i_core_timer_overflow_flag & i_core_timer_overflow_enable) |
    (i_periodic_tick_flag & i_periodic_tick_enable);
wire ptim_req = (i_capture_flag & i_capture_int_enable) |
    (i_compare_flag & i_compare_int_enable) |
    (i_prog_timer_overflow_flag & i_prog_timer_overflow_enable);
wire ser_req = i_serial_done_flag & i_serial_int_enable;
wire ana_req = (i_comparator_one_flag | i_comparator_two_flag) &
    i_comparator_int_enable;
wire any_req = ext_req | ctim_req | ptim_req | ser_req | ana_req;
wire rst_req = (|i_reset_sources) |
    (i_watchdog_timeout & i_watchdog_enable_option);

reg [2:0] pick_src;
always @*
begin
    if (ext_req)
        pick_src = `CIS_SRC_EXT;
    else if (ctim_req)
        pick_src = `CIS_SRC_CTIM;
    else if (ptim_req)
        pick_src = `CIS_SRC_PTIM;
    else if (ser_req)
        pick_src = `CIS_SRC_SER;
    else
        pick_src = `CIS_SRC_ANA;
end

reg [15:0] vec_base;
always @*
begin
    case (src_ff)
        `CIS_SRC_RESET: vec_base = `CIS_VEC_RESET;
        `CIS_SRC_SWI: vec_base = `CIS_VEC_SWI;
        `CIS_SRC_EXT: vec_base = `CIS_VEC_EXT;
        `CIS_SRC_CTIM: vec_base = `CIS_VEC_CTIM;
        `CIS_SRC_PTIM: vec_base = `CIS_VEC_PTIM;
        `CIS_SRC_SER: vec_base = `CIS_VEC_SER;
        default: vec_base = `CIS_VEC_ANA;
    endcase
end

// Flag register and stacked bytes
wire [7:0] ccr = {`CIS_CCR_ONES, h_ff, i_bit_ff, n_ff, z_ff, c_ff};
wire [15:0] sp_addr = {`CIS_SP_HIGH, sp_ff};
wire [15:0] sp_next_addr = {`CIS_SP_HIGH, sp_ff + 6'h01};
reg [7:0] push_byte;
always @*
begin
    case (cnt_ff)
        3'h0: push_byte = pc_ff[7:0];
        3'h1: push_byte = {`CIS_PC_ONES, pc_ff[12:8]};
        3'h2: push_byte = i_idx;
        3'h3: push_byte = i_acc;
        default: push_byte = ccr;
    endcase
end

// Interrupt decision at the instruction boundary
wire boundary = (state_ff == S_RUN) & i_instr_done;
wire take_swi = boundary & i_software_trap_instr;
wire take_irq = boundary & ~i_software_trap_instr & ~i_bit_ff &
    any_req;
wire take_call = boundary & i_call_instr;
wire take_rti = boundary & i_return_from_handler_instr;
wire take_ret = boundary & i_return_instr;
wire [2:0] last_push = kind_ff ? `CIS_CALL_BYTES - 3'h1 :
    `CIS_INT_BYTES - 3'h1;

// Sequencer
always @(posedge i_clk)
begin
    if (!i_nrst)
    begin
        state_ff <= S_VEC;
        kind_ff <= K_INT;
        cnt_ff <= 3'h0;
        ph_ff <= 1'b0;
        src_ff <= `CIS_SRC_RESET;
        pc_ff <= 16'h0000;
        tgt_ff <= 16'h0000;
        sp_ff <= `CIS_SP_RESET;
        i_bit_ff <= 1'b1;
        rest_acc_ff <= 8'h00;
        rest_idx_ff <= 8'h00;
        rest_ccr_ff <= 8'hFF;
        rest_valid_ff <= 1'b0;
        vec_hi_ff <= 8'h00;
    end
    else if (rst_req)
    begin
        state_ff <= S_VEC;
        cnt_ff <= 3'h0;
        src_ff <= `CIS_SRC_RESET;
        sp_ff <= `CIS_SP_RESET;
        i_bit_ff <= 1'b1;
        rest_valid_ff <= 1'b0;
    end
    else
    begin
        rest_valid_ff <= 1'b0;
        case (state_ff)
            S_RUN:
            begin
                if (i_jump)
                    pc_ff <= i_jump_addr;
                else if (i_fetch)
                    pc_ff <= pc_ff + 16'h0001;
                if (i_clear_mask_instruction)
                    i_bit_ff <= 1'b0;
                else if (i_set_mask_instr)
                    i_bit_ff <= 1'b1;
                cnt_ff <= 3'h0;
                ph_ff <= 1'b0;
                if (take_swi || take_irq)
                begin
                    state_ff <= S_PUSH;
                    kind_ff <= K_INT;
                    src_ff <= take_swi ? `CIS_SRC_SWI : pick_src;
                end
                else if (take_call)
                begin
                    state_ff <= S_PUSH;
                    kind_ff <= K_SUB;
                    tgt_ff <= i_jump_addr;
                end
                else if (take_rti || take_ret)
                begin
                    state_ff <= S_PULL;
                    kind_ff <= take_ret ? K_SUB : K_INT;
                    cnt_ff <= take_ret ? `CIS_CALL_BYTES - 3'h1 :
                        `CIS_INT_BYTES - 3'h1;
                end
            end
            S_PUSH:
            begin
                sp_ff <= sp_ff - 6'h01;
                if (cnt_ff == last_push)
                begin
                    cnt_ff <= 3'h0;
                    if (kind_ff == K_SUB)
                    begin
                        pc_ff <= tgt_ff;
                        state_ff <= S_RUN;
                    end
                    else
                    begin
                        i_bit_ff <= 1'b1;
                        state_ff <= S_VEC;
                    end
                end
                else
                    cnt_ff <= cnt_ff + 3'h1;
            end
            S_PULL:
            begin
                ph_ff <= ~ph_ff;
                if (!ph_ff)
                    sp_ff <= sp_ff + 6'h01;
                else
                begin
                    case (kind_ff ? cnt_ff : cnt_ff)
                        3'h4: rest_ccr_ff <= i_mem_rdata;
                        3'h3: rest_acc_ff <= i_mem_rdata;
                        3'h2: rest_idx_ff <= i_mem_rdata;
                        3'h1: pc_ff[15:8] <= {3'h0, i_mem_rdata[4:0]};
                        default: pc_ff[7:0] <= i_mem_rdata;
                    endcase
                    if (cnt_ff == 3'h0)
                    begin
                        state_ff <= S_RUN;
                        if (kind_ff == K_INT)
                        begin
                            i_bit_ff <= rest_ccr_ff[`CIS_CCR_I];
                            rest_valid_ff <= 1'b1;
                        end
                    end
                    else
                        cnt_ff <= cnt_ff - 3'h1;
                end
            end
            default:
            begin
                if (cnt_ff == 3'h1)
                    vec_hi_ff <= i_mem_rdata;
                if (cnt_ff == 3'h2)
                begin
                    pc_ff <= {vec_hi_ff, i_mem_rdata};
                    state_ff <= S_RUN;
                    cnt_ff <= 3'h0;
                end
                else
                    cnt_ff <= cnt_ff + 3'h1;
            end
        endcase
    end
end

// Result flags; reset leaves them alone
reg [4:0] half_sum;
reg [8:0] full_sum;
wire carry_in = (i_alu_op == `CIS_OP_ADC || i_alu_op == `CIS_OP_SBC) &
    c_ff;
always @*
begin
    if (i_alu_op == `CIS_OP_SUB || i_alu_op == `CIS_OP_SBC)
    begin
        half_sum = {1'b0, i_alu_a[3:0]} - {1'b0, i_alu_b[3:0]} -
            {4'h0, carry_in};
        full_sum = {1'b0, i_alu_a} - {1'b0, i_alu_b} - {8'h00, carry_in};
    end
    else
    begin
        half_sum = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]} +
            {4'h0, carry_in};
        full_sum = {1'b0, i_alu_a} + {1'b0, i_alu_b} + {8'h00, carry_in};
    end
end

wire in_rti_done = (state_ff == S_PULL) & ph_ff & (cnt_ff == 3'h0) &
    (kind_ff == K_INT);

always @(posedge i_clk)
begin
    if (in_rti_done)
    begin
        h_ff <= rest_ccr_ff[`CIS_CCR_H];
        n_ff <= rest_ccr_ff[`CIS_CCR_N];
        z_ff <= rest_ccr_ff[`CIS_CCR_Z];
        c_ff <= rest_ccr_ff[`CIS_CCR_C];
    end
    else if (mul_done)
    begin
        h_ff <= 1'b0;
        c_ff <= 1'b0;
    end
    else if (state_ff == S_RUN)
    begin
        case (i_alu_op)
            `CIS_OP_ADD, `CIS_OP_ADC:
            begin
                h_ff <= half_sum[4];
                c_ff <= full_sum[8];
                n_ff <= full_sum[7];
                z_ff <= (full_sum[7:0] == 8'h00);
                alu_res_ff <= full_sum[7:0];
            end
            `CIS_OP_SUB, `CIS_OP_SBC:
            begin
                c_ff <= full_sum[8];
                n_ff <= full_sum[7];
                z_ff <= (full_sum[7:0] == 8'h00);
                alu_res_ff <= full_sum[7:0];
            end
            `CIS_OP_LOGIC:
            begin
                n_ff <= i_alu_a[7];
                z_ff <= (i_alu_a == 8'h00);
                alu_res_ff <= i_alu_a;
            end
            `CIS_OP_SETC: c_ff <= 1'b1;
            `CIS_OP_CLRC: c_ff <= 1'b0;
            default: alu_res_ff <= alu_res_ff;
        endcase
    end
end

// Pin synchronisers and external pending latch
wire vec_fetch = (state_ff == S_VEC) & (cnt_ff == 3'h0) & ~rst_req;
always @(posedge i_clk)
begin
    if (!i_nrst)
    begin
        ext_meta_ff <= 1'b1;
        ext_sync_ff <= 1'b1;
        ext_prev_ff <= 1'b1;
        pa_meta_ff <= 4'h0;
        pa_sync_ff <= 4'h0;
        pa_prev_ff <= 4'h0;
        ext_pend_ff <= 1'b0;
    end
    else
    begin
        ext_meta_ff <= i_ext_pin_n;
        ext_sync_ff <= ext_meta_ff;
        ext_prev_ff <= ext_sync_ff;
        pa_meta_ff <= i_port_a_low_pins;
        pa_sync_ff <= pa_meta_ff;
        pa_prev_ff <= pa_sync_ff;
        if (ext_set)
            ext_pend_ff <= 1'b1;
        else if (i_ext_clear || (vec_fetch && src_ff == `CIS_SRC_EXT))
            ext_pend_ff <= 1'b0;
    end
end

// Outputs
assign o_mem_req = (state_ff == S_PUSH) | ((state_ff == S_PULL) & ~ph_ff) |
    ((state_ff == S_VEC) & (cnt_ff != 3'h2));
assign o_mem_we = (state_ff == S_PUSH);
assign o_mem_addr = (state_ff == S_PUSH) ? sp_addr :
    (state_ff == S_PULL) ? sp_next_addr :
    (cnt_ff == 3'h0) ? vec_base : vec_base + 16'h0001;
assign o_mem_wdata = push_byte;
assign o_pc = pc_ff;
assign o_ccr = ccr;
assign o_sp_addr = sp_addr;
assign o_busy = (state_ff != S_RUN) | mul_busy;
assign o_alu_result = alu_res_ff;
assign o_mul_product = mul_product;
assign o_mul_done = mul_done;
assign o_restore_valid = rest_valid_ff;
assign o_restore_acc = rest_acc_ff;
assign o_restore_idx = rest_idx_ff;
assign o_vec_ack = vec_fetch ? (5'h01 << (src_ff - `CIS_SRC_EXT)) &
    {5{src_ff >= `CIS_SRC_EXT}} : 5'h00;
assign o_ext_pending = ext_pend_ff;
assign o_reset_req = rst_req;

endmodule // cis_core

/* testbench/cis_core_props.sv */
// Concurrent checks on the interrupt sequencer's ports.
// Assumes it is bound to every cis_core instance.
`timescale 1ns/10ps
`include "cis_defs.vh"

module cis_core_props
(
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Watched inputs
    input wire i_fetch,
    input wire i_jump,
    input wire i_instr_done,
    input wire i_clear_mask_instruction,
    input wire i_multiply_instr,
    // Watched outputs
    input wire o_mem_req,
    input wire o_mem_we,
    input wire [15:0] o_mem_addr,
    input wire [15:0] o_pc,
    input wire [7:0] o_ccr,
    input wire [15:0] o_sp_addr,
    input wire o_busy,
    input wire o_mul_done,
    input wire o_restore_valid,
    input wire [4:0] o_vec_ack,
    input wire o_ext_pending,
    input wire o_reset_req
);
    wire [15:0] ack_vec = o_vec_ack[0] ? `CIS_VEC_EXT :
        o_vec_ack[1] ? `CIS_VEC_CTIM : o_vec_ack[2] ? `CIS_VEC_PTIM :
        o_vec_ack[3] ? `CIS_VEC_SER : `CIS_VEC_ANA;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_ccr_top_ones: assert property (o_ccr[7:5] == `CIS_CCR_ONES)
        else $error("flag register top bits not ones");
    a_pc_step: assert property (!o_busy && i_fetch && !i_jump &&
        !i_instr_done && !o_reset_req |=> o_pc == $past(o_pc) + 16'h0001)
        else $error("address did not step by one");
    a_mask_clear_cause: assert property ($fell(o_ccr[3]) |->
        $past(i_clear_mask_instruction) || o_restore_valid ||
        $past(o_restore_valid)) else $error("mask cleared without cause");
    a_reset_state: assert property (disable iff (1'b0)
        !i_nrst |=> o_ccr[3] && o_sp_addr == 16'h00FF)
        else $error("reset left mask or stack wrong");
    a_mul_length: assert property (i_multiply_instr && !o_busy |=>
        !o_mul_done [*8] ##[2:4] o_mul_done)
        else $error("multiply length wrong");
    a_sp_window: assert property (o_sp_addr[15:6] == `CIS_SP_HIGH)
        else $error("stack address outside window");
    a_ack_vector: assert property (|o_vec_ack |-> $onehot(o_vec_ack) &&
        o_mem_req && !o_mem_we && o_mem_addr == ack_vec)
        else $error("acknowledge without its vector read");
    a_ack_masked: assert property (|o_vec_ack |-> o_ccr[3] && o_busy)
        else $error("vector fetched before mask set");
    a_ext_cleared: assert property (o_vec_ack[0] |=> !o_ext_pending)
        else $error("external latch not cleared");
    a_reset_vector: assert property ($rose(i_nrst) |-> o_mem_req &&
        o_mem_addr == `CIS_VEC_RESET ##1 o_mem_addr == 16'h1FFF)
        else $error("reset vector not fetched");
    a_entry_boundary: assert property ($rose(o_mem_we) |->
        $past(i_instr_done)) else $error("stacking began mid instruction");
endmodule // cis_core_props

bind cis_core cis_core_props u_cis_core_props (.*);

/* testbench/cis_periph_model.sv */
// Peripheral flags that hold their requests until serviced.
// Assumes the bench pulses i_set for one cycle to raise a flag.
`timescale 1ns/10ps

module cis_periph_model
(
    // Clock
    input wire i_clk,
    // Flag control
    input wire [7:0] i_set,
    input wire [4:0] i_vec_ack,
    // Flags to the core
    output reg [7:0] o_flags
);
    wire [7:0] clr_mask = {{2{i_vec_ack[4]}}, i_vec_ack[3],
        {3{i_vec_ack[2]}}, {2{i_vec_ack[1]}}};

    initial o_flags = 8'h00;

    // Flags hold until the matching vector fetch clears them
    always @(posedge i_clk)
        o_flags <= (o_flags & ~clr_mask) | i_set;
endmodule // cis_periph_model

/* testbench/test_cis_core.sv */
// Bench for cis_core with stack memory and peripheral model.
// Assumes the design, peripheral model and checker are compiled first.
`timescale 1ns/10ps
`include "cis_defs.vh"

module test_cis_core;
    typedef struct {int s; int a; logic [15:0] v;} cis_note_t;
    logic i_clk = 0, i_nrst = 0, i_fetch = 0, i_jump = 0, i_instr_done = 0;
    logic i_clear_mask_instruction = 0, i_set_mask_instr = 0;
    logic i_software_trap_instr = 0, i_return_from_handler_instr = 0;
    logic i_call_instr = 0, i_return_instr = 0, i_multiply_instr = 0;
    logic i_watchdog_timeout = 0, i_watchdog_enable_option = 0;
    logic i_ext_pin_n = 1, i_port_a_request_option = 0, i_ext_clear = 0;
    logic i_ext_request_enable = 0, i_core_timer_overflow_enable = 0;
    logic i_periodic_tick_enable = 0, i_capture_int_enable = 0;
    logic i_compare_int_enable = 0, i_prog_timer_overflow_enable = 0;
    logic i_serial_int_enable = 0, i_comparator_int_enable = 0;
    logic [2:0] i_alu_op = 0;
    logic [3:0] i_reset_sources = 0, i_port_a_low_pins = 0, f = 0;
    logic [7:0] i_acc = 0, i_idx = 0, i_alu_a = 0, i_alu_b = 0;
    logic [7:0] i_mem_rdata = 0, pset = 0, mem [0:511];
    logic [15:0] i_jump_addr = 0, got;
    wire i_core_timer_overflow_flag, i_periodic_tick_flag, i_capture_flag;
    wire i_compare_flag, i_prog_timer_overflow_flag, i_serial_done_flag;
    wire i_comparator_one_flag, i_comparator_two_flag, o_mem_req, o_mem_we;
    wire o_busy, o_mul_done, o_restore_valid, o_ext_pending, o_reset_req;
    wire [15:0] o_mem_addr, o_pc, o_sp_addr, o_mul_product;
    wire [7:0] o_mem_wdata, o_ccr, o_alu_result, o_restore_acc, o_restore_idx;
    wire [4:0] o_vec_ack;
    wire [8:0] mi = {o_mem_addr[12], o_mem_addr[7:0]};
    cis_note_t q[$];
    int fails = 0, compares = 0;

    cis_core u_cis_core (.*);
    cis_periph_model u_cis_periph_model
    (
        .i_clk(i_clk),
        .i_set(pset),
        .i_vec_ack(o_vec_ack),
        .o_flags({i_comparator_two_flag, i_comparator_one_flag,
            i_serial_done_flag, i_prog_timer_overflow_flag, i_compare_flag,
            i_capture_flag, i_periodic_tick_flag, i_core_timer_overflow_flag})
    );

    always #2 i_clk = ~i_clk;

    // Stack and vector memory, read data one cycle after request
    always @(posedge i_clk)
    begin
        if (o_mem_req && o_mem_we)
            mem[mi] <= o_mem_wdata;
        i_mem_rdata <= o_mem_req ? mem[mi] : ~i_mem_rdata;
    end

    // Oldest note is compared once its result is on the outputs
    always @(negedge i_clk)
        if (q.size() > 0 && (q[0].s != 3 || o_mul_done))
        begin
            case (q[0].s)
                0: got = o_pc;
                1: got = {8'h00, o_ccr};
                2: got = o_sp_addr;
                3: got = o_mul_product;
                4: got = {8'h00, mem[q[0].a]};
                5: got = {15'h0000, o_ext_pending};
                6: got = {15'h0000, o_reset_req};
                default: got = {15'h0000, o_busy};
            endcase
            check(got, q[0].v);
            void'(q.pop_front());
        end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input int s, input int a, input logic [15:0] v);
        q.push_back('{s, a, v});
        wait (q.size() == 0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
        cyc(1);
    endtask

    task automatic idle;
        cyc(2);
        for (int n = 0; n < 200 && o_busy !== 1'b0; n++)
            cyc(1);
    endtask

    task automatic return_from_handler_instr;
        i_return_from_handler_instr = 1;
        pulse(i_instr_done);
        i_return_from_handler_instr = 0;
        idle;
    endtask

    function automatic logic [15:0] vpc(input logic [15:0] v);
        return {4'h1, v[3:0], 8'h5A};
    endfunction

    function automatic logic [15:0] ccr_e(input logic m);
        return {8'h00, 3'h7, f[3], m, f[2:0]};
    endfunction

    task automatic fin(input string n);
        $display("Test %s done", n);
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        logic [2:0] op;
        logic [8:0] r;
        logic [15:0] jt;
        logic c;
        void'($urandom(32'h6F3E));
        for (int i = 0; i < 16; i++)
            mem[496 + i] = i[0] ? 8'h5A : {4'h1, 4'(i)};
        cyc(8);
        i_nrst = 1;
        idle;
        note(0, 0, vpc(`CIS_VEC_RESET));
        for (int i = 0; i < 24; i++)
        begin
            cyc(1);
            op = i ? 3'($urandom_range(7, 1)) : 3'h1;
            i_alu_a = 8'($urandom);
            i_alu_b = 8'($urandom);
            c = (op == 3'h2 || op == 3'h4) && f[0];
            r = op > 3'h2 ? {1'b0, i_alu_a} - i_alu_b - c
                : {1'b0, i_alu_a} + i_alu_b + c;
            if (op == 3'h5)
                r = {f[0], i_alu_a};
            if (op < 3'h3)
                f[3] = ({1'b0, i_alu_a[3:0]} + i_alu_b[3:0] + c) > 5'h0F;
            if (op < 3'h6)
                f[2:0] = {r[7], r[7:0] == 8'h00, r[8]};
            else
                f[0] = op == 3'h6;
            i_alu_op = op;
            cyc(1);
            i_alu_op = 0;
            note(1, 0, ccr_e(1'b1));
        end
        pulse(i_fetch);
        pulse(i_fetch);
        note(0, 0, vpc(`CIS_VEC_RESET) + 16'h0002);
        jt = {8'h03, 8'($urandom)};
        i_jump_addr = jt;
        pulse(i_jump);
        note(0, 0, jt);
        pulse(i_multiply_instr);
        note(3, 0, i_alu_a * i_alu_b);
        f = f & 4'h6;
        fin("flags, address and multiply");
        {i_ext_request_enable, i_core_timer_overflow_enable,
            i_periodic_tick_enable, i_capture_int_enable, i_compare_int_enable,
            i_prog_timer_overflow_enable, i_serial_int_enable,
            i_comparator_int_enable} = 8'hFF;
        i_port_a_request_option = 1;
        i_port_a_low_pins = 4'($urandom_range(15, 1));
        pset = 8'($urandom) | 8'h65;
        i_acc = 8'($urandom);
        i_idx = 8'($urandom);
        cyc(1);
        pset = 0;
        cyc(4);
        i_port_a_low_pins = 0;
        note(5, 0, 16'h0001);
        pulse(i_instr_done);
        note(7, 0, 16'h0000);
        i_software_trap_instr = 1;
        pulse(i_instr_done);
        i_software_trap_instr = 0;
        idle;
        note(0, 0, vpc(`CIS_VEC_SWI));
        note(2, 0, 16'h00FA);
        note(4, 9'h0FF, jt[7:0]);
        note(4, 9'h0FE, {3'h7, jt[12:8]});
        note(4, 9'h0FD, i_idx);
        note(4, 9'h0FC, i_acc);
        note(4, 9'h0FB, ccr_e(1'b1));
        pulse(i_clear_mask_instruction);
        for (int k = 0; k < 5; k++)
        begin
            pulse(i_instr_done);
            idle;
            note(0, 0, vpc(16'h1FFA - 16'(2 * k)));
            note(1, 0, ccr_e(1'b1));
            return_from_handler_instr;
            note(1, 0, ccr_e(1'b0));
        end
        return_from_handler_instr;
        note(0, 0, jt);
        note(1, 0, ccr_e(1'b1));
        note(2, 0, 16'h00FF);
        fin("priority");
        pulse(i_clear_mask_instruction);
        i_ext_request_enable = 0;
        i_port_a_low_pins = 4'h1;
        cyc(4);
        pulse(i_instr_done);
        note(7, 0, 16'h0000);
        i_ext_request_enable = 1;
        pulse(i_instr_done);
        idle;
        note(0, 0, vpc(`CIS_VEC_EXT));
        i_port_a_low_pins = 0;
        fin("external enable");
        i_watchdog_timeout = 1;
        cyc(1);
        note(6, 0, 16'h0000);
        i_watchdog_enable_option = 1;
        cyc(1);
        note(6, 0, 16'h0001);
        i_watchdog_timeout = 0;
        idle;
        note(0, 0, vpc(`CIS_VEC_RESET));
        i_reset_sources = 4'($urandom_range(15, 1));
        cyc(1);
        note(6, 0, 16'h0001);
        i_reset_sources = 0;
        cyc(1);
        i_nrst = 0;
        cyc(2);
        note(2, 0, 16'h00FF);
        note(1, 0, ccr_e(1'b1));
        i_nrst = 1;
        idle;
        fin("resets");
        tally_and_finish;
    end

    // Limit is over ten times the expected run length
    initial
    begin
        #40000;
        fails++;
        tally_and_finish;
    end
endmodule // test_cis_core
